// file: rtl/acr_pkg.sv
package acr_pkg;
  // ----------------------------------------
  // register offsets (byte offsets on an 8-bit space)
  // ----------------------------------------
  localparam logic [7:0] OFS_PORT_A_PINS      = 8'h05;
  localparam logic [7:0] OFS_CONVERTER_CTRL   = 8'h08;
  localparam logic [7:0] OFS_INTERRUPT_CTRL   = 8'h0B;
  localparam logic [7:0] OFS_INTERRUPT_CTRL_H = 8'h8B;
  localparam logic [7:0] OFS_PORT_A_DIR       = 8'h85;
  localparam logic [7:0] OFS_PIN_CONFIG       = 8'h88;
  localparam logic [7:0] OFS_CONV_RESULT      = 8'h89;
  localparam logic [7:0] OFS_IRQ_STATUS       = 8'hC0;
  localparam logic [7:0] OFS_IRQ_ENABLE       = 8'hC1;
  localparam logic [7:0] OFS_IRQ_CLEAR        = 8'hC2;

  // ----------------------------------------
  // converter_control field positions
  // ----------------------------------------
  localparam int BIT_POWER_ON   = 0;
  localparam int BIT_DONE_FLAG  = 1;
  localparam int BIT_GO         = 2;
  localparam int BIT_CHAN_LO    = 3;
  localparam int BIT_CHAN_HI    = 4;
  localparam int BIT_CLK_LO     = 6;
  localparam int BIT_CLK_HI     = 7;
  localparam logic [7:0] CTRL_WMASK   = 8'hDF;
  // interrupt_control fields
  localparam int BIT_CONV_IRQ_EN   = 6;
  localparam int BIT_GLOBAL_IRQ_EN = 7;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_CONVERTER_CTRL = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_CTRL = 8'h00;
  localparam logic [7:0] RST_PORT_A_DIR     = 8'h1F;
  localparam logic [7:0] RST_PIN_CONFIG     = 8'h00;
  localparam logic [7:0] RST_PORT_A_OUT     = 8'h00;
  localparam logic [7:0] PORT_A_MASK        = 8'h1F;
  localparam logic [7:0] PIN_CFG_MASK       = 8'h03;

  // ----------------------------------------
  // clock select codes and timing
  // ----------------------------------------
  localparam logic [1:0] CLKSEL_DIV2  = 2'h0;
  localparam logic [1:0] CLKSEL_DIV8  = 2'h1;
  localparam logic [1:0] CLKSEL_DIV32 = 2'h2;
  localparam logic [1:0] CLKSEL_RC    = 2'h3;
  localparam int CLK_NS           = 100;
  localparam int RC_TAD_NS        = 4000;
  localparam int RC_TAD_CYC       = RC_TAD_NS / CLK_NS;
  localparam int INSTR_CYC        = 4;
  localparam int CONV_BITS        = 8;
  localparam int SETUP_TADS       = 2;
  localparam int CODE_STEPS       = 256;

  // converter states, counting up in binary along the usual path
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_CONV  = 2'b11,
    ST_SETUP = 2'b10
  } acr_state_t;
endpackage

// file: rtl/acr_tad_gen.sv
`timescale 1ns/1ns
// ----------------------------------------
// conversion clock tick generator
// ----------------------------------------
module acr_tad_gen
  import acr_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_run,    // counts only while converting
  input  wire logic [1:0] i_sel,    // clock select code
  output logic            o_tick    // one cycle per conversion clock period
);
  logic [7:0] cnt;       // period counter
  logic [7:0] next_cnt;
  logic [7:0] limit;     // period minus one

  // period chosen from the select code
  always_comb begin
    case (i_sel)
      CLKSEL_DIV2:  limit = 8'h01;
      CLKSEL_DIV8:  limit = 8'h07;
      CLKSEL_DIV32: limit = 8'h1F;
      default:      limit = 8'(RC_TAD_CYC - 1);
    endcase
    // restart from zero whenever stopped
    if (!i_run || cnt >= limit) begin
      next_cnt = 8'h00;
    end else begin
      next_cnt = cnt + 8'h01;
    end
    o_tick = i_run && (cnt >= limit);
  end

  // counter register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 8'h00;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule

// file: rtl/acr_sar.sv
`timescale 1ns/1ns
// ----------------------------------------
// successive approximation bit engine
// ----------------------------------------
module acr_sar
  import acr_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_start,   // load sample, begin at msb
  input  wire logic       i_abort,   // drop the trial silently
  input  wire logic       i_tick,    // one bit per tick
  input  wire logic       i_cmp_hi,  // comparator: input at or above trial code
  output logic [7:0]      o_trial,   // code presented to the dac
  output logic            o_done     // one-cycle pulse, o_trial final
);
  logic [7:0] trial;      // working code
  logic [7:0] bitp;       // bit under test
  logic [7:0] next_trial;
  logic [7:0] next_bitp;
  logic       done;       // last bit decided on the previous edge
  logic       next_done;

  // keep or drop the bit under test each tick
  always_comb begin
    next_trial = trial;
    next_bitp  = bitp;
    next_done  = 1'b0;
    if (i_abort) begin
      next_bitp = 8'h00;
    end else if (i_start) begin
      next_trial = 8'h80;
      next_bitp  = 8'h80;
    end else if (i_tick && bitp != 8'h00) begin
      // ideal binary coding: each kept bit is a 1/256 multiple
      if (!i_cmp_hi) begin
        next_trial = trial & ~bitp;
      end
      next_bitp  = bitp >> 1;
      next_trial = next_trial | (bitp >> 1);
      // flag one cycle later so the trial already holds bit zero
      next_done  = (bitp == 8'h01);
    end
  end

  // engine registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      trial <= 8'h00;
      bitp  <= 8'h00;
      done  <= 1'b0;
    end else begin
      trial <= next_trial;
      bitp  <= next_bitp;
      done  <= next_done;
    end
  end

  assign o_trial = trial;
  assign o_done  = done;
endmodule

// file: rtl/acr_top.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
// Contract
// RULE_01 - reset loads every register reset value
// RULE_02 - reset powers off, aborts, no completion
// RULE_03 - result register untouched by reset
// RULE_04 - unimplemented bits read zero, ignore writes
// RULE_05 - ideal 8-bit binary, 1/256 steps
// RULE_06 - software keeps conversion clock period legal
// RULE_07 - software picks rc clock before sleep
// RULE_08 - clearing go aborts, result kept
// RULE_09 - completion loads result, clears go, flags
// RULE_10 - clock code 11 is rc, sleeps
// RULE_11 - rc clock waits one instruction cycle
// RULE_12 - channel select picks one of four
module acr_top
  import acr_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_addr,      // register address
  input  wire logic [7:0] i_wdata,     // write data
  input  wire logic       i_wr,        // write strobe
  input  wire logic       i_rd,        // read strobe
  output logic [7:0]      o_rdata,     // read data, cycle after i_rd
  input  wire logic       i_sleep,     // device is asleep
  input  wire logic [4:0] i_port_a,    // port a pin levels (async)
  output logic [4:0]      o_port_a,    // port a output values
  output logic [4:0]      o_port_a_oe, // port a drive enables
  input  wire logic       i_cmp_hi,    // comparator result (async)
  output logic [7:0]      o_dac_code,  // trial code to the dac
  output logic [1:0]      o_chan,      // channel to sample
  output logic            o_conv_on,   // analog power enable
  output logic            o_irq        // level interrupt
);
  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  logic [7:0]  ctrl;        // converter_control
  logic [7:0]  intc;        // interrupt_control
  logic [7:0]  pdir;        // port_a_direction
  logic [7:0]  pcfg;        // pin_config
  logic [7:0]  pout;        // port_a output latch
  logic [7:0]  result;      // conversion_result, never reset
  logic [1:0]  irq_stat;    // sticky: bit0 done, bit1 abort
  logic [1:0]  irq_en;      // irq enable mask
  logic [7:0]  rdata;       // registered read data
  logic [1:0]  chan_lat;    // channel latched at acquisition
  logic [7:0]  dly;         // pre-conversion wait counter
  logic [1:0]  setup;       // setup tad counter
  acr_state_t  state;
  logic [7:0]  next_ctrl;
  logic [7:0]  next_intc;
  logic [7:0]  next_pdir;
  logic [7:0]  next_pcfg;
  logic [7:0]  next_pout;
  logic [7:0]  next_result;
  logic [1:0]  next_irq_stat;
  logic [1:0]  next_irq_en;
  logic [7:0]  next_rdata;
  logic [1:0]  next_chan_lat;
  logic [7:0]  next_dly;
  logic [1:0]  next_setup;
  acr_state_t  next_state;
  // synchronisers
  logic [2:0]  cmp_sync;    // comparator three-stage
  logic        cmp_stable;  // agreed comparator level
  logic [4:0]  pa_s1;       // port a stage one
  logic [4:0]  pa_s2;
  logic [4:0]  pa_s3;
  logic [4:0]  pa_stable;
  // engine links
  logic        tad_run;
  logic        tick;
  logic        sar_start;
  logic        sar_abort;
  logic        sar_done;
  logic [7:0]  trial;
  logic        ev_done;     // conversion finished this cycle
  logic        ev_abort;    // conversion abandoned this cycle

  // decode shared by the write path and the sequencer's go-clear check
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // change counts when stages two and three agree
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cmp_sync   <= 3'h0;
      cmp_stable <= 1'b0;
      pa_s1      <= 5'h00;
      pa_s2      <= 5'h00;
      pa_s3      <= 5'h00;
      pa_stable  <= 5'h00;
    end else begin
      cmp_sync <= {cmp_sync[1:0], i_cmp_hi};
      if (cmp_sync[1] == cmp_sync[2]) begin
        cmp_stable <= cmp_sync[2];
      end
      pa_s1 <= i_port_a;
      pa_s2 <= pa_s1;
      pa_s3 <= pa_s2;
      pa_stable <= (pa_s2 & pa_s3) | (pa_stable & (pa_s2 | pa_s3));
    end
  end

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  acr_tad_gen u_tad (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_run  (tad_run),
    .i_sel  (ctrl[BIT_CLK_HI:BIT_CLK_LO]),
    .o_tick (tick)
  );

  acr_sar u_sar (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_start  (sar_start),
    .i_abort  (sar_abort),
    .i_tick   (tick),
    .i_cmp_hi (cmp_stable),
    .o_trial  (trial),
    .o_done   (sar_done)
  );

  // ----------------------------------------
  // converter sequencer
  // ----------------------------------------
  // conversion timing and abort decisions
  always_comb begin
    logic go;
    logic rc_sel;
    logic clr_go;
    go            = ctrl[BIT_GO];
    rc_sel        = (ctrl[BIT_CLK_HI:BIT_CLK_LO] == CLKSEL_RC);
    clr_go        = i_wr && hit(i_addr, OFS_CONVERTER_CTRL) && !i_wdata[BIT_GO];
    next_state    = state;
    next_dly      = dly;
    next_setup    = setup;
    next_chan_lat = chan_lat;
    sar_start     = 1'b0;
    sar_abort     = 1'b0;
    ev_done       = 1'b0;
    ev_abort      = 1'b0;
    tad_run       = 1'b0;
    // RULE_12 channel sampled at acquisition
    if (state == ST_IDLE) begin
      next_chan_lat = ctrl[BIT_CHAN_HI:BIT_CHAN_LO];
    end
    case (state)
      ST_IDLE: begin
        if (go && ctrl[BIT_POWER_ON]) begin
          // RULE_11 rc waits one instruction
          next_dly   = rc_sel ? 8'(INSTR_CYC - 1) : 8'h00;
          next_state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (dly == 8'h00) begin
          next_setup = 2'(SETUP_TADS);
          next_state = ST_SETUP;
        end else begin
          next_dly = dly - 8'h01;
        end
      end
      ST_SETUP: begin
        tad_run = 1'b1;
        if (tick) begin
          next_setup = setup - 2'h1;
          if (setup == 2'h1) begin
            sar_start  = 1'b1;
            next_state = ST_CONV;
          end
        end
      end
      ST_CONV: begin
        tad_run = 1'b1;
        if (sar_done) begin
          ev_done    = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // RULE_08 abort on go clear
    // RULE_10 only rc survives sleep
    if (state != ST_IDLE && !ev_done &&
        (clr_go || !ctrl[BIT_POWER_ON] || (i_sleep && !rc_sel))) begin
      sar_abort  = 1'b1;
      ev_abort   = 1'b1;
      next_state = ST_IDLE;
    end
  end

  // ----------------------------------------
  // register file next values
  // ----------------------------------------
  always_comb begin
    logic [7:0] wctrl;
    wctrl         = (i_wdata & CTRL_WMASK) | (ctrl & ~CTRL_WMASK);
    next_ctrl     = ctrl;
    next_intc     = intc;
    next_pdir     = pdir;
    next_pcfg     = pcfg;
    next_pout     = pout;
    next_result   = result;
    next_irq_en   = irq_en;
    next_irq_stat = irq_stat;
    next_rdata    = 8'h00;
    // RULE_04 masked writes keep unused bits zero
    if (i_wr) begin
      if (hit(i_addr, OFS_CONVERTER_CTRL)) begin
        next_ctrl = wctrl & 8'hDF;
      end
      if (hit(i_addr, OFS_INTERRUPT_CTRL) || hit(i_addr, OFS_INTERRUPT_CTRL_H)) begin
        next_intc = i_wdata;
      end
      if (hit(i_addr, OFS_PORT_A_DIR)) begin
        next_pdir = i_wdata & PORT_A_MASK;
      end
      if (hit(i_addr, OFS_PIN_CONFIG)) begin
        next_pcfg = i_wdata & PIN_CFG_MASK;
      end
      if (hit(i_addr, OFS_PORT_A_PINS)) begin
        next_pout = i_wdata & PORT_A_MASK;
      end
      if (hit(i_addr, OFS_CONV_RESULT)) begin
        next_result = i_wdata;
      end
      if (hit(i_addr, OFS_IRQ_ENABLE)) begin
        next_irq_en = i_wdata[1:0];
      end
      if (hit(i_addr, OFS_IRQ_CLEAR)) begin
        next_irq_stat = irq_stat & ~i_wdata[1:0];
      end
    end
    // aborted go stays cleared even if power dropped
    if (ev_abort) begin
      next_ctrl[BIT_GO] = 1'b0;
    end
    // RULE_09 load result, clear go, flag
    if (ev_done) begin
      next_result = trial;
      next_ctrl[BIT_GO]        = 1'b0;
      next_ctrl[BIT_DONE_FLAG] = 1'b1;
      next_irq_stat[0]         = 1'b1;
    end
    if (ev_abort) begin
      next_irq_stat[1] = 1'b1;
    end
    // read mux, unmapped reads return zero
    if (i_rd) begin
      case (i_addr)
        OFS_CONVERTER_CTRL:   next_rdata = ctrl;
        OFS_INTERRUPT_CTRL:   next_rdata = intc;
        OFS_INTERRUPT_CTRL_H: next_rdata = intc;
        OFS_PORT_A_DIR:       next_rdata = pdir;
        OFS_PIN_CONFIG:       next_rdata = pcfg;
        OFS_PORT_A_PINS:      next_rdata = {3'h0, pa_stable};
        OFS_CONV_RESULT:      next_rdata = result;
        OFS_IRQ_STATUS:       next_rdata = {6'h00, irq_stat};
        OFS_IRQ_ENABLE:       next_rdata = {6'h00, irq_en};
        default:              next_rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // registers with reset
  // ----------------------------------------
  // RULE_01 reset values loaded
  // RULE_02 reset idles the sequencer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl     <= RST_CONVERTER_CTRL;
      intc     <= RST_INTERRUPT_CTRL;
      pdir     <= RST_PORT_A_DIR;
      pcfg     <= RST_PIN_CONFIG;
      pout     <= RST_PORT_A_OUT;
      irq_stat <= 2'h0;
      irq_en   <= 2'h0;
      rdata    <= 8'h00;
      chan_lat <= 2'h0;
      dly      <= 8'h00;
      setup    <= 2'h0;
      state    <= ST_IDLE;
    end else begin
      ctrl     <= next_ctrl;
      intc     <= next_intc;
      pdir     <= next_pdir;
      pcfg     <= next_pcfg;
      pout     <= next_pout;
      irq_stat <= next_irq_stat;
      irq_en   <= next_irq_en;
      rdata    <= next_rdata;
      chan_lat <= next_chan_lat;
      dly      <= next_dly;
      setup    <= next_setup;
      state    <= next_state;
    end
  end

  // RULE_03 result kept across reset
  always_ff @(posedge i_clk) begin
    result <= next_result;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // RULE_05 trial code drives the ideal dac
  assign o_dac_code  = trial;
  assign o_chan      = chan_lat;
  assign o_conv_on   = ctrl[BIT_POWER_ON] && !(i_sleep && ctrl[BIT_CLK_HI:BIT_CLK_LO] != CLKSEL_RC);
  assign o_rdata     = rdata;
  assign o_port_a    = pout[4:0];
  assign o_port_a_oe = ~pdir[4:0];
  // level irq from enabled sticky bits
  assign o_irq       = |(irq_stat & irq_en);
endmodule

// file: tb/acr_assertions.sv
`timescale 1ns/1ns
// ----------------------------------------
// port-level checks for the converter block
// ----------------------------------------
module acr_assertions
  import acr_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] o_rdata,
  input  wire logic       i_sleep,
  input  wire logic [4:0] o_port_a_oe,
  input  wire logic [1:0] o_chan,
  input  wire logic       o_conv_on,
  input  wire logic       o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic [7:0] last_wdata; // data of the latest bus write

  // remember write data for readback checks
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      last_wdata <= 8'h00;
    end else if (i_wr) begin
      last_wdata <= i_wdata;
    end
  end

  // ----------------------------------------
  // bus steps
  // ----------------------------------------
  sequence s_wr(logic [7:0] a);
    i_wr && i_addr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    i_rd && i_addr == a;
  endsequence

  // reset itself is the cause here, so nothing disables it
  property p_rst_quiet;
    disable iff (1'b0) i_rst ##1 i_rst |-> !o_irq && !o_conv_on && o_port_a_oe == 5'h00 && o_rdata == 8'h00;
  endproperty
  property p_rd_idle;
    !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  property p_pincfg;
    s_wr(OFS_PIN_CONFIG) ##1 s_rd(OFS_PIN_CONFIG) |=> o_rdata == {6'h00, last_wdata[1:0]};
  endproperty
  property p_ctrl;
    s_wr(OFS_CONVERTER_CTRL) ##1 s_rd(OFS_CONVERTER_CTRL)
      |=> o_rdata[7:6] == last_wdata[7:6] && o_rdata[4:3] == last_wdata[4:3] && !o_rdata[5];
  endproperty
  property p_dir;
    s_rd(OFS_PORT_A_DIR) |=> o_rdata[7:5] == 3'h0;
  endproperty
  // an oscillator clock cannot survive sleep
  property p_sleep_off;
    s_wr(OFS_CONVERTER_CTRL) ##0 i_wdata[7:6] != CLKSEL_RC ##1 (!i_wr throughout (##[0:30] i_sleep [*2]))
      |-> !o_conv_on;
  endproperty
  property p_chan;
    s_wr(OFS_CONVERTER_CTRL) ##0 !i_wdata[BIT_GO] ##1 !i_wr [*2] |-> o_chan == last_wdata[4:3];
  endproperty
  property p_irq_mask;
    s_wr(OFS_IRQ_ENABLE) ##0 i_wdata == 8'h00 ##1 !i_wr |=> !o_irq;
  endproperty

  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs active during reset");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  a_pincfg: assert property (p_pincfg)
    else $error("pin config readback wrong");
  a_ctrl: assert property (p_ctrl)
    else $error("control readback wrong");
  a_dir: assert property (p_dir)
    else $error("direction upper bits not zero");
  a_sleep_off: assert property (p_sleep_off)
    else $error("converter powered in sleep");
  a_chan: assert property (p_chan)
    else $error("channel output not updated");
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt not masked");
endmodule

bind acr_top acr_assertions u_acr_assertions (
  .i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_sleep, .o_port_a_oe, .o_chan, .o_conv_on, .o_irq
);

// file: tb/acr_analog_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// analog side: four inputs and a comparator
// ----------------------------------------
module acr_analog_model (
  input  wire logic            i_clk,
  input  wire logic [3:0][9:0] i_level,    // input levels in quarter steps
  input  wire logic [7:0]      i_dac_code, // trial code
  input  wire logic [1:0]      i_chan,     // selected input
  input  wire logic            i_power,    // converter powered
  output logic                 o_cmp_hi    // input at or above trial
);
  logic       toggle = 1'b0; // junk while unpowered
  logic [9:0] vin;           // level on the chosen input

  // an unpowered comparator must not look valid
  always_ff @(posedge i_clk) begin
    toggle <= ~toggle;
  end
  assign vin = i_level[i_chan];
  assign o_cmp_hi = i_power ? (vin >= {i_dac_code, 2'b00}) : toggle;
endmodule

// file: tb/adc_control_reset_regs_test.sv
`timescale 1ns/1ns
// ----------------------------------------
// register-level bench
// ----------------------------------------
module adc_control_reset_regs_test
  import acr_pkg::*;
;
  logic       i_clk   = 1'b0;  // 10 MHz
  logic       i_rst   = 1'b1;  // async, high
  logic [7:0] i_addr  = 8'h00; // bus address
  logic [7:0] i_wdata = 8'h00; // bus data
  logic       i_wr    = 1'b0;  // write strobe
  logic       i_rd    = 1'b0;  // read strobe
  logic       i_sleep = 1'b0;  // device sleep
  logic       cmp_hi;          // comparator
  logic [7:0] o_rdata, o_dac_code;
  logic [4:0] o_port_a, o_port_a_oe;
  logic [1:0] o_chan;
  logic       o_conv_on, o_irq;
  int         fails   = 0;
  int         n_tests = 0;
  int         cycles  = 0;
  // levels per input, boundary pairs around code steps
  logic [3:0][9:0] levels = {10'h1FF, 10'h004, 10'h003, 10'h3FF};
  logic [7:0] codes [4] = '{8'hFF, 8'h00, 8'h01, 8'h7F};
  logic [7:0] raddr [7] = '{OFS_CONVERTER_CTRL, OFS_PIN_CONFIG, OFS_PORT_A_DIR, OFS_INTERRUPT_CTRL,
                            OFS_IRQ_STATUS, OFS_IRQ_ENABLE, 8'h40};
  logic [7:0] rval [7]  = '{RST_CONVERTER_CTRL, RST_PIN_CONFIG, RST_PORT_A_DIR, RST_INTERRUPT_CTRL,
                            8'h00, 8'h00, 8'h00};

  always #50 i_clk = ~i_clk;

  acr_top dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_sleep(i_sleep), .i_port_a(5'h15), .o_port_a(o_port_a),
    .o_port_a_oe(o_port_a_oe), .i_cmp_hi(cmp_hi), .o_dac_code(o_dac_code), .o_chan(o_chan),
    .o_conv_on(o_conv_on), .o_irq(o_irq)
  );
  acr_analog_model u_model (
    .i_clk(i_clk), .i_level(levels), .i_dac_code(o_dac_code), .i_chan(o_chan),
    .i_power(o_conv_on), .o_cmp_hi(cmp_hi)
  );

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // strobes stay up; callers lower them, never twice per step
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
  endtask
  // data stands only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    op(1'b0, 1'b1, a, 8'h00);
    i_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, o_rdata);
    @(posedge i_clk);
  endtask
  task automatic idle(input int n);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    repeat (n) @(posedge i_clk);
  endtask
  // bounded wait for the level interrupt
  task automatic wait_irq;
    int k = 0;
    idle(1);
    while (o_irq !== 1'b1 && k < 1000) begin
      @(posedge i_clk);
      k++;
    end
    chk("irq raised", 8'h01, {7'h00, o_irq});
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard, far above the few thousand cycles needed
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    logic [7:0] base;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int j = 0; j < 7; j++) begin
      rchk(raddr[j], rval[j]);
    end
    chk("drive enables", 8'h00, {3'h0, o_port_a_oe});
    $display("test reset values done");
    wr(OFS_PIN_CONFIG, 8'hFF);
    rchk(OFS_PIN_CONFIG, 8'h03);
    wr(OFS_PORT_A_DIR, 8'hE0);
    rchk(OFS_PORT_A_DIR, 8'h00);
    wr(OFS_PORT_A_PINS, 8'hEA);
    rchk(OFS_PORT_A_PINS, 8'h15);
    chk("port out", 8'h0A, {3'h0, o_port_a});
    chk("drive enables", 8'h1F, {3'h0, o_port_a_oe});
    wr(OFS_CONVERTER_CTRL, 8'h20);
    rchk(OFS_CONVERTER_CTRL, 8'h00);
    wr(8'h40, 8'hFF);
    rchk(8'h40, 8'h00);
    $display("test unimplemented bits done");
    // every clock code, one input each
    // too-short periods only see a full-scale input
    wr(OFS_IRQ_ENABLE, 8'h01);
    for (int i = 0; i < 4; i++) begin
      base = {i[1:0], 1'b0, i[1:0], 3'b001};
      wr(OFS_CONVERTER_CTRL, base);
      rchk(OFS_CONVERTER_CTRL, base);
      wr(OFS_CONVERTER_CTRL, base | 8'h04);
      // sleep only on the rc clock
      if (i == 3) i_sleep <= 1'b1;
      wait_irq();
      i_sleep <= 1'b0;
      rchk(OFS_CONV_RESULT, codes[i]);
      rchk(OFS_CONVERTER_CTRL, base | 8'h02);
      wr(OFS_IRQ_ENABLE, 8'h00);
      idle(2);
      chk("irq masked", 8'h00, {7'h00, o_irq});
      rchk(OFS_IRQ_STATUS, 8'h01);
      wr(OFS_IRQ_ENABLE, 8'h01);
      wr(OFS_IRQ_CLEAR, 8'h01);
      idle(2);
      chk("irq cleared", 8'h00, {7'h00, o_irq});
      wr(OFS_CONVERTER_CTRL, 8'h00);
    end
    $display("test conversions done");
    // abort by clearing go, then by sleeping on an oscillator clock
    wr(OFS_CONV_RESULT, 8'h5A);
    for (int m = 0; m < 2; m++) begin
      wr(OFS_IRQ_CLEAR, 8'h03);
      wr(OFS_CONVERTER_CTRL, 8'h41);
      wr(OFS_CONVERTER_CTRL, 8'h45);
      idle(20);
      if (m == 0) wr(OFS_CONVERTER_CTRL, 8'h41);
      else i_sleep <= 1'b1;
      idle(200);
      chk("power", (m == 0) ? 8'h01 : 8'h00, {7'h00, o_conv_on});
      i_sleep <= 1'b0;
      rchk(OFS_CONV_RESULT, 8'h5A);
      rchk(OFS_IRQ_STATUS, 8'h02);
      chk("irq after abort", 8'h00, {7'h00, o_irq});
    end
    $display("test aborts done");
    // reset during conversion setup, before the first bit trial
    wr(OFS_CONV_RESULT, 8'hA5);
    wr(OFS_CONVERTER_CTRL, 8'hC1);
    wr(OFS_CONVERTER_CTRL, 8'hC5);
    idle(30);
    i_rst <= 1'b1;
    idle(2);
    i_rst <= 1'b0;
    idle(500);
    chk("power", 8'h00, {7'h00, o_conv_on});
    rchk(OFS_CONV_RESULT, 8'hA5);
    rchk(OFS_CONVERTER_CTRL, 8'h00);
    rchk(OFS_IRQ_STATUS, 8'h00);
    rchk(OFS_PORT_A_DIR, 8'h1F);
    $display("test mid reset done");
    complete_run();
  end
endmodule
